// ==== core/bit_set_reset_defines.vh ====
// Behaviour
// - Latch set forces the operand bit to 1 when its condition is true.
// - Latch clear forces the operand bit to 0 when its condition is true.
// - Immediate variants drive a built-in output bit at execution, not scan end.
// - Latch instructions refuse timer and counter operands.
// - Inside an interlocked or jumped section the target bit keeps its value.
// - Any number of set and clear instructions share bit storage in order.
// - Multi-bit set writes 1 into a run of bits upward; count 0 does nothing.
// - Multi-bit clear writes 0 into a run of bits upward; count 0 does nothing.
// - Multi-bit error flag is set when the start bit exceeds 15, else cleared.
// - Bits set by multi-bit set stay ordinary storage any instruction may clear.
// - Single-bit set forces to 1 the bit chosen by word and bit number.
// - Single-bit clear forces to 0 the bit chosen by word and bit number.
// - Falling-edge pulse holds its bit at 1 for one scan after a 1 to 0 input.
// - Differentiated variants act only on a transition of the condition.
// - Single-bit error flag is set when the bit number exceeds 15, else cleared.
`ifndef BIT_SET_RESET_DEFINES_VH
`define BIT_SET_RESET_DEFINES_VH

`define OP_FALLING_EDGE_PULSE 10'h00E
`define OP_MULTI_BIT_SET      10'h212
`define OP_MULTI_BIT_CLEAR    10'h213
`define OP_SINGLE_BIT_SET     10'h214
`define OP_SINGLE_BIT_CLEAR   10'h215
`define OP_LATCH_SET          10'h3F0
`define OP_LATCH_CLEAR        10'h3F1

`define DIFF_NONE             2'h0
`define DIFF_RISING           2'h1
`define DIFF_FALLING          2'h2

`define AREA_TIMER            3'h4
`define AREA_COUNTER          3'h5

`define WORD_BITS             16
`define BIT_INDEX_MAX         16'h000F
`define BUILTIN_OUT_WORD      6'h00

`endif

// ==== core/bit_run_mask.v ====
`timescale 1ns/100ps
`default_nettype none
module bit_run_mask #(
   parameter W  = 16,
   parameter SW = 4,
   parameter CW = 16
) (
   // Run position within the current word.
   input  wire [SW-1:0] i_start,
   input  wire [CW-1:0] i_remaining,
   // Bits covered in this word.
   output reg  [W-1:0]  o_mask,
   output reg  [SW:0]   o_used
);
   reg [SW:0] avail;
   integer    i;

   // The run covers bits from the start upward and stops at the word's top bit.
   always @* begin
      avail = W[SW:0] - {1'b0, i_start};
      if (i_remaining < {{(CW-SW-1){1'b0}}, avail}) begin
         o_used = i_remaining[SW:0];
      end else begin
         o_used = avail;
      end
      o_mask = {W{1'b0}};
      for (i = 0; i < W; i = i + 1) begin
         if ((i >= i_start) && (i < i_start + o_used)) begin
            o_mask[i] = 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== core/bit_set_reset_unit.v ====
`timescale 1ns/100ps
`default_nettype none
`include "bit_set_reset_defines.vh"
module bit_set_reset_unit #(
   parameter AW    = 6,
   parameter DEPTH = 64,
   parameter SLOTS = 16,
   parameter SLW   = 4
) (
   // Clock and reset.
   input  wire          i_sys_clk,
   input  wire          i_resetn,
   // Instruction request from the scan sequencer.
   input  wire          i_instr_valid,
   input  wire [9:0]    i_opcode,
   input  wire          i_exec_cond,
   input  wire          i_section_active,
   input  wire [1:0]    i_diff_mode,
   input  wire [SLW-1:0] i_diff_slot,
   input  wire          i_immediate,
   input  wire [2:0]    i_operand_area,
   input  wire [AW-1:0] i_word_addr,
   input  wire [15:0]   i_bit_num,
   input  wire [15:0]   i_bit_count,
   input  wire          i_scan_end,
   // Storage read port.
   input  wire [AW-1:0] i_rd_addr,
   output reg  [15:0]   o_rd_data,
   // Instruction status.
   output reg           o_ready,
   output reg           o_done,
   output reg           o_refused,
   output reg           o_operand_error_flag,
   // Built-in physical outputs.
   output reg  [15:0]   o_builtin_out
);
   localparam ST_IDLE = 2'b01;
   localparam ST_RUN  = 2'b10;
   localparam [AW-1:0] OUT_WORD = `BUILTIN_OUT_WORD;

   // Reset synchroniser.
   reg          rst_meta;
   reg          rst_sync;

   // Run sequencing.
   reg  [1:0]   state;
   reg  [1:0]   next_state;
   reg  [AW-1:0] run_addr;
   reg  [AW-1:0] next_run_addr;
   reg  [3:0]   run_start;
   reg  [3:0]   next_run_start;
   reg  [15:0]  run_left;
   reg  [15:0]  next_run_left;
   reg          run_set;
   reg          next_run_set;

   // Bit storage and previous conditions.
   reg  [15:0]  mem [0:DEPTH-1];
   reg          diff_mem [0:SLOTS-1];

   // Write port and status decode.
   reg          wr_en;
   reg  [AW-1:0] wr_addr;
   reg  [15:0]  wr_data;
   reg          err_upd;
   reg          err_val;
   reg          next_refused;
   reg          next_done;
   reg          cond_ok;
   reg  [15:0]  cur_word;
   reg  [15:0]  next_builtin_out;
   reg          next_error_flag;

   // Request decode.
   wire [15:0]  run_mask;
   wire [4:0]   run_used;
   wire [15:0]  sel_word;
   wire [3:0]   bit_idx;
   wire         range_ok;
   wire         tc_area;
   wire         prev_cond;
   wire         idle_req;
   wire         exec_go;
   wire         fall_pulse;
   wire         imm_hit;
   wire         run_last;
   wire         diff_upd;
   integer      k;
   integer      n;

   // Reset release through two flip-flops.
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // Bits of the current word covered by the run.
   bit_run_mask #(
      .W  (16),
      .SW (4),
      .CW (16)
   ) u_run_mask (
      .i_start     (run_start),
      .i_remaining (run_left),
      .o_mask      (run_mask),
      .o_used      (run_used)
   );

   // Request decode and the previous condition of this instruction instance.
   assign sel_word  = mem[i_word_addr];
   assign bit_idx   = i_bit_num[3:0];
   assign range_ok  = (i_bit_num <= `BIT_INDEX_MAX);
   assign tc_area   = (i_operand_area == `AREA_TIMER) || (i_operand_area == `AREA_COUNTER);
   assign prev_cond = diff_mem[i_diff_slot];
   assign idle_req  = i_instr_valid && (state == ST_IDLE);
   assign fall_pulse = prev_cond && !i_exec_cond;
   assign run_last   = (run_left == {11'h000, run_used});
   assign diff_upd   = idle_req && i_section_active;

   // Plain variants act on a true condition, prefixed ones on its edge only.
   always @* begin
      case (i_diff_mode)
         `DIFF_NONE: begin
            cond_ok = i_exec_cond;
         end
         `DIFF_RISING: begin
            cond_ok = i_exec_cond && !prev_cond;
         end
         `DIFF_FALLING: begin
            cond_ok = !i_exec_cond && prev_cond;
         end
         default: begin
            cond_ok = 1'b0;
         end
      endcase
   end

   // A skipped section neither executes nor changes its target.
   assign exec_go = idle_req && i_section_active && cond_ok;

   // Multi-bit run sequencing and single-cycle instruction decode.
   always @* begin
      next_state     = state;
      next_run_addr  = run_addr;
      next_run_start = run_start;
      next_run_left  = run_left;
      next_run_set   = run_set;
      wr_en          = 1'b0;
      wr_addr        = i_word_addr;
      wr_data        = sel_word;
      cur_word       = mem[run_addr];
      err_upd        = 1'b0;
      err_val        = 1'b0;
      next_refused   = 1'b0;
      next_done      = 1'b0;
      case (state)
         ST_RUN: begin
            wr_en   = 1'b1;
            wr_addr = run_addr;
            if (run_set) begin
               wr_data = cur_word | run_mask;
            end else begin
               wr_data = cur_word & ~run_mask;
            end
            next_run_addr  = run_addr + {{(AW-1){1'b0}}, 1'b1};
            next_run_start = 4'h0;
            next_run_left  = run_left - {11'h000, run_used};
            if (run_last) begin
               next_state = ST_IDLE;
               next_done  = 1'b1;
            end
         end
         ST_IDLE: begin
            if (idle_req) begin
               next_done = 1'b1;
               if (i_opcode == `OP_FALLING_EDGE_PULSE) begin
                  if (i_section_active) begin
                     wr_en            = 1'b1;
                     wr_data[bit_idx] = fall_pulse;
                  end
               end else if (exec_go) begin
                  case (i_opcode)
                     `OP_LATCH_SET, `OP_LATCH_CLEAR: begin
                        if (tc_area) begin
                           next_refused = 1'b1;
                        end else begin
                           wr_en            = 1'b1;
                           wr_data[bit_idx] = (i_opcode == `OP_LATCH_SET);
                        end
                     end
                     `OP_SINGLE_BIT_SET, `OP_SINGLE_BIT_CLEAR: begin
                        err_upd = 1'b1;
                        err_val = !range_ok;
                        if (tc_area) begin
                           next_refused = 1'b1;
                        end else if (range_ok) begin
                           wr_en            = 1'b1;
                           wr_data[bit_idx] = (i_opcode == `OP_SINGLE_BIT_SET);
                        end
                     end
                     `OP_MULTI_BIT_SET, `OP_MULTI_BIT_CLEAR: begin
                        err_upd = 1'b1;
                        err_val = !range_ok;
                        if (range_ok && (i_bit_count != 16'h0000)) begin
                           next_state     = ST_RUN;
                           next_done      = 1'b0;
                           next_run_addr  = i_word_addr;
                           next_run_start = bit_idx;
                           next_run_left  = i_bit_count;
                           next_run_set   = (i_opcode == `OP_MULTI_BIT_SET);
                        end
                     end
                     default: begin
                        next_refused = 1'b1;
                     end
                  endcase
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Only single-bit style writes from an idle request refresh at once.
   assign imm_hit = wr_en && (state == ST_IDLE) && i_immediate && (wr_addr == OUT_WORD);

   // Physical output image: an immediate hit refreshes only the bit it writes.
   always @* begin
      next_builtin_out = o_builtin_out;
      if (i_scan_end) begin
         next_builtin_out = mem[OUT_WORD];
      end
      if (imm_hit) begin
         next_builtin_out[bit_idx] = wr_data[bit_idx];
      end
   end

   // Error flag follows the range check of each executed single or multi-bit instruction.
   always @* begin
      next_error_flag = o_operand_error_flag;
      if (err_upd) begin
         next_error_flag = err_val;
      end
   end

   // Control and status registers.
   always @(posedge i_sys_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         state                <= ST_IDLE;
         run_addr             <= {AW{1'b0}};
         run_start            <= 4'h0;
         run_left             <= 16'h0000;
         run_set              <= 1'b0;
         o_ready              <= 1'b1;
         o_done               <= 1'b0;
         o_refused            <= 1'b0;
         o_operand_error_flag <= 1'b0;
         o_builtin_out        <= 16'h0000;
         o_rd_data            <= 16'h0000;
      end else begin
         state     <= next_state;
         run_addr  <= next_run_addr;
         run_start <= next_run_start;
         run_left  <= next_run_left;
         run_set   <= next_run_set;
         o_ready   <= (next_state == ST_IDLE);
         o_done    <= next_done;
         o_refused <= next_refused;
         o_operand_error_flag <= next_error_flag;
         o_builtin_out        <= next_builtin_out;
         o_rd_data <= mem[i_rd_addr];
      end
   end

   // Shared bit storage, one read-modify-write per cycle in program order.
   always @(posedge i_sys_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         for (k = 0; k < DEPTH; k = k + 1) begin
            mem[k] <= 16'h0000;
         end
      end else if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Previous condition per instruction instance, held while its section is skipped.
   always @(posedge i_sys_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         for (n = 0; n < SLOTS; n = n + 1) begin
            diff_mem[n] <= 1'b0;
         end
      end else if (diff_upd) begin
         diff_mem[i_diff_slot] <= i_exec_cond;
      end
   end
endmodule
`default_nettype wire

// ==== testbench/bit_set_reset_unit_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "bit_set_reset_defines.vh"
module bit_set_reset_unit_asserts #(
   parameter AW  = 6,
   parameter SLW = 4
) (
   // Clock, reset and request.
   input wire          i_sys_clk,
   input wire          i_resetn,
   input wire          i_instr_valid,
   input wire [9:0]    i_opcode,
   input wire          i_exec_cond,
   input wire          i_section_active,
   input wire [1:0]    i_diff_mode,
   input wire          i_immediate,
   input wire [2:0]    i_operand_area,
   input wire [AW-1:0] i_word_addr,
   input wire [15:0]   i_bit_num,
   input wire [15:0]   i_bit_count,
   input wire          i_scan_end,
   // Status.
   input wire          o_ready,
   input wire          o_done,
   input wire          o_refused,
   input wire          o_operand_error_flag,
   input wire [15:0]   o_builtin_out
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   wire       take  = i_instr_valid && o_ready;
   wire       go    = take && i_exec_cond && i_section_active && i_diff_mode == 2'h0;
   wire       tc    = i_operand_area == `AREA_TIMER || i_operand_area == `AREA_COUNTER;
   wire       multi = i_opcode == `OP_MULTI_BIT_SET || i_opcode == `OP_MULTI_BIT_CLEAR;
   wire       sngl  = i_opcode == `OP_SINGLE_BIT_SET || i_opcode == `OP_SINGLE_BIT_CLEAR;
   wire       imm0  = go && !tc && i_immediate && i_word_addr == 0 && !i_scan_end;
   wire       bad   = i_bit_num > `BIT_INDEX_MAX;
   wire [3:0] lbit  = i_bit_num[3:0];
   reg        want_ok;
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) want_ok <= 1'b0;
      else if (go && multi && !bad) want_ok <= 1'b1;
      else if (o_done) want_ok <= 1'b0;
   end
   a_quick_done: assert property (take && !multi |=> o_done)
      else $error("done missing after a one-cycle request");
   a_latch_tc_refused: assert property (go && tc && i_opcode[9:1] == 9'h1F8 |=> o_refused)
      else $error("timer or counter target not refused");
   a_multi_err_set: assert property (go && multi && bad |=> o_operand_error_flag)
      else $error("bad start bit left error flag low");
   a_multi_err_clear: assert property (want_ok && o_done |-> !o_operand_error_flag)
      else $error("good start bit left error flag high");
   a_run_bounded: assert property (go && multi && !bad && i_bit_count != 0
      |=> !o_ready ##[1:10] o_done)
      else $error("bit run did not hold off and finish");
   a_single_err_set: assert property (go && sngl && bad |=> o_operand_error_flag)
      else $error("bad bit number left error flag low");
   a_single_err_clear: assert property (go && sngl && !bad |=> !o_operand_error_flag)
      else $error("good bit number left error flag high");
   a_hold_inactive: assert property (take && !i_section_active && (sngl || multi)
      |=> $stable(o_operand_error_flag))
      else $error("inactive section changed error flag");
   a_imm_set: assert property (imm0 && i_opcode == `OP_LATCH_SET
      |=> o_builtin_out[$past(lbit)])
      else $error("immediate set not on output");
   a_imm_clear: assert property (imm0 && i_opcode == `OP_LATCH_CLEAR
      |=> !o_builtin_out[$past(lbit)])
      else $error("immediate clear not on output");
endmodule
bind bit_set_reset_unit bit_set_reset_unit_asserts #(.AW(AW), .SLW(SLW)) u_chk (.*);
`default_nettype wire

// ==== testbench/scan_sequencer_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module scan_sequencer_model (
   // Status from the unit.
   input  wire         i_clk,
   input  wire         i_ready,
   input  wire         i_done,
   // Instruction request.
   output logic        o_valid,
   output logic [9:0]  o_op,
   output logic [7:0]  o_flags,
   output logic [3:0]  o_slot,
   output logic [5:0]  o_word,
   output logic [15:0] o_bit,
   output logic [15:0] o_cnt
);
   int hung = 0;
   initial {o_valid, o_op, o_flags, o_slot, o_word, o_bit, o_cnt} = '0;
   // Holds the request until taken, then scrambles the released lines except the flags.
   task automatic issue(input logic [9:0] op, input logic [5:0] w, input logic [15:0] b,
                        input logic [15:0] n, input logic [3:0] s, input logic [7:0] f);
      int k;
      @(posedge i_clk);
      #1;
      {o_valid, o_op, o_flags, o_slot, o_word, o_bit, o_cnt} = {1'b1, op, f, s, w, b, n};
      for (k = 0; k < 40 && !i_ready; k++) begin
         @(posedge i_clk);
         #1;
      end
      if (!i_ready) hung++;
      @(posedge i_clk);
      #1;
      o_valid = 1'b0;
      {o_op, o_slot, o_word, o_bit, o_cnt} = ~{o_op, o_slot, o_word, o_bit, o_cnt};
      for (k = 0; k < 40 && !i_done; k++) begin
         @(posedge i_clk);
         #1;
      end
      if (!i_done) hung++;
   endtask
endmodule
`default_nettype wire

// ==== testbench/test_bit_set_reset_unit.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "bit_set_reset_defines.vh"
module test_bit_set_reset_unit;
   logic        i_sys_clk = 0;
   logic        i_resetn = 0;
   logic        i_scan_end = 0;
   logic [5:0]  i_rd_addr = 0;
   wire         vld, rdy, dne, rfs, erf;
   wire  [9:0]  opc;
   wire  [7:0]  flg;
   wire  [3:0]  slt;
   wire  [5:0]  wrd;
   wire  [15:0] bno, cnt, rdd, bout;
   logic [15:0] exp_mem [0:63];
   logic [15:0] prev_flag = 0;
   logic        exp_err = 0;
   logic        exp_ref = 0;
   logic [31:0] seed = 32'h6fa5eddd;
   logic [9:0]  ops [0:5] = '{`OP_LATCH_SET, `OP_LATCH_CLEAR, `OP_MULTI_BIT_SET,
                              `OP_MULTI_BIT_CLEAR, `OP_SINGLE_BIT_SET, `OP_SINGLE_BIT_CLEAR};
   int          err_count = 0, total_checks = 0;
   scan_sequencer_model i_seq (.i_clk(i_sys_clk), .i_ready(rdy), .i_done(dne), .o_valid(vld),
      .o_op(opc), .o_flags(flg), .o_slot(slt), .o_word(wrd), .o_bit(bno), .o_cnt(cnt));
   bit_set_reset_unit i_dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_instr_valid(vld),
      .i_opcode(opc), .i_exec_cond(flg[7]), .i_section_active(flg[6]), .i_diff_mode(flg[4:3]),
      .i_diff_slot(slt), .i_immediate(flg[5]), .i_operand_area(flg[2:0]), .i_word_addr(wrd),
      .i_bit_num(bno), .i_bit_count(cnt), .i_scan_end(i_scan_end), .i_rd_addr(i_rd_addr),
      .o_rd_data(rdd), .o_ready(rdy), .o_done(dne), .o_refused(rfs),
      .o_operand_error_flag(erf), .o_builtin_out(bout));
   initial forever #4 i_sys_clk = ~i_sys_clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task check(input logic [15:0] seen, input logic [15:0] want);
      total_checks++;
      if (seen !== want) begin
         err_count++;
         $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   // Reference behaviour of one request; flags are cond, active, imm, mode, area.
   task automatic apply(input logic [9:0] op, input logic [5:0] w, input logic [15:0] b,
                        input logic [15:0] n, input logic [3:0] s, input logic [7:0] f);
      logic fire, tc;
      logic [5:0] aw;
      int i;
      tc = f[2:0] == `AREA_TIMER || f[2:0] == `AREA_COUNTER;
      case (f[4:3])
         2'h0: fire = f[7];
         2'h1: fire = f[7] && !prev_flag[s];
         2'h2: fire = !f[7] && prev_flag[s];
         default: fire = 1'b0;
      endcase
      exp_ref = 1'b0;
      if (!f[6]) return;
      exp_ref = fire && tc && (op[9:1] == 9'h1F8 || op[9:1] == 9'h10A);
      if (op == `OP_FALLING_EDGE_PULSE) exp_mem[w][b[3:0]] = prev_flag[s] & ~f[7];
      else if (fire && op[9:1] == 9'h1F8 && !tc) exp_mem[w][b[3:0]] = !op[0];
      else if (fire && op[9:1] == 9'h10A) begin
         exp_err = b > 15;
         if (!tc && b < 16) exp_mem[w][b[3:0]] = !op[0];
      end else if (fire && op[9:1] == 9'h109) begin
         exp_err = b > 15;
         for (i = 0; i < n && b < 16; i++) begin
            aw = w + 6'((b + i) / 16);
            exp_mem[aw][(b + i) % 16] = !op[0];
         end
      end
      prev_flag[s] = f[7];
   endtask
   task automatic step(input logic [9:0] op, input logic [5:0] w, input logic [15:0] b,
                       input logic [15:0] n, input logic [3:0] s, input logic [7:0] f);
      i_seq.issue(op, w, b, n, s, f);
      apply(op, w, b, n, s, f);
      check({15'h0, erf}, {15'h0, exp_err});
      check({15'h0, rfs}, {15'h0, exp_ref});
      for (int j = 0; j < 12; j++) begin
         i_rd_addr = 6'(j);
         @(posedge i_sys_clk);
         #1;
         check(rdd, exp_mem[j]);
      end
   endtask
   task results;
      err_count += i_seq.hung;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      for (int j = 0; j < 64; j++) exp_mem[j] = 0;
      repeat (4) @(posedge i_sys_clk);
      #1 i_resetn = 1;
      repeat (5) @(posedge i_sys_clk);
      step(`OP_LATCH_SET, 1, 7, 0, 0, 8'hC0);
      step(`OP_LATCH_CLEAR, 1, 7, 0, 0, 8'hC0);
      step(`OP_LATCH_SET, 1, 7, 0, 0, 8'hC4);
      step(`OP_MULTI_BIT_SET, 5, 5, 20, 1, 8'hC0);
      step(`OP_SINGLE_BIT_CLEAR, 5, 9, 0, 1, 8'hC0);
      step(`OP_MULTI_BIT_CLEAR, 6, 3, 20, 1, 8'hC0);
      step(`OP_MULTI_BIT_SET, 63, 14, 4, 1, 8'hC0);
      step(`OP_MULTI_BIT_SET, 2, 16, 5, 1, 8'hC0);
      step(`OP_MULTI_BIT_SET, 2, 0, 0, 1, 8'hC0);
      step(`OP_SINGLE_BIT_SET, 3, 16, 0, 1, 8'hC0);
      step(`OP_SINGLE_BIT_SET, 3, 4, 0, 1, 8'h80);
      step(`OP_SINGLE_BIT_SET, 4, 0, 0, 6, 8'hC8);
      step(`OP_SINGLE_BIT_CLEAR, 4, 0, 0, 7, 8'hC0);
      step(`OP_SINGLE_BIT_SET, 4, 0, 0, 6, 8'hC8);
      step(`OP_SINGLE_BIT_SET, 4, 2, 0, 10, 8'hD0);
      step(`OP_SINGLE_BIT_SET, 4, 2, 0, 10, 8'h50);
      step(`OP_SINGLE_BIT_SET, 4, 3, 0, 11, 8'hD8);
      for (int j = 0; j < 3; j++) step(`OP_FALLING_EDGE_PULSE, 4, 1, 0, 9, j ? 8'h40 : 8'hC0);
      step(`OP_LATCH_SET, 0, 3, 0, 0, 8'hE0);
      check({15'h0, bout[3]}, 16'h0001);
      step(`OP_LATCH_CLEAR, 0, 3, 0, 0, 8'hE0);
      check({15'h0, bout[3]}, 16'h0000);
      for (int k = 0; k < 60; k++) begin
         seed = lfsr(seed);
         step(ops[seed[2:0] % 6], seed[5:3], seed[16] ? 16'(seed[20:17]) : 16'(seed[21:17]),
              16'(seed[27:22]), seed[31:28], {seed[0] | seed[1], seed[2] | seed[9], seed[8],
              seed[11:10], seed[6:4]});
      end
      i_scan_end = 1;
      @(posedge i_sys_clk);
      #1 i_scan_end = 0;
      check(bout, exp_mem[0]);
      results;
   end
endmodule
`default_nettype wire
